// [inc/pm_diag_pkg.sv]
// Package: offsets, field positions, reset values and carriers of the block
package pm_diag_pkg;

  // ******************************************************************
  // Register offsets (byte addresses in configuration space)
  // ******************************************************************
  localparam logic [7:0] IDENT_OFFSET = 8'h00;
  localparam logic [7:0] DIAG_OFFSET = 8'h93;
  localparam logic [7:0] CAP_ID_OFFSET = 8'hA0;
  localparam logic [7:0] NEXT_PTR_OFFSET = 8'hA1;
  localparam logic [7:0] PWR_CAP_OFFSET = 8'hA2;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int DIAG_MASK_BIT = 7;
  localparam int DIAG_ONE_BIT = 6;
  localparam int DIAG_ROUTE_BIT = 5;
  localparam int DIAG_DTX_OFF_BIT = 4;
  localparam int DIAG_RETRY_BIT = 3;
  localparam int DIAG_CB_TIM_BIT = 2;
  localparam int DIAG_HOST_TIM_BIT = 1;
  localparam int PWR_CAP_COLD_BIT = 15;

  // ******************************************************************
  // Reset and fixed values
  // ******************************************************************
  localparam logic [7:0] DIAG_RESET = 8'h60;
  localparam logic [7:0] CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
  localparam logic [15:0] PWR_CAP_RESET = 16'hFE12;
  localparam logic [31:0] IDENT_MASKED = 32'hFFFFFFFF;
  localparam logic [3:0] ROUTE_ALL_ZERO = 4'h0;

  // ******************************************************************
  // Timing counts in PCI clocks
  // ******************************************************************
  localparam logic [6:0] RETRY_SHORT_CYC = 7'h10;
  localparam logic [6:0] RETRY_LONG_CYC = 7'h40;
  localparam int DISCARD_SHORT_EXP = 10;
  localparam int DISCARD_LONG_EXP = 15;
  localparam logic [15:0] DISCARD_SHORT_CYC = 16'(1 << DISCARD_SHORT_EXP);

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [3:0] compat_805_hi;
    logic compat_803_bit4;
  } route_in_t;

endpackage

// [core/pm_capability_diag_regs.sv]
// Diagnostic and power-management capability configuration registers
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (R1) Diagnostic bit 7 set makes identification reads return all ones.
// (R2) Diagnostic bit 6 is read-only and always reads 1.
// (R3) Bit 5 picks how status-change interrupts are routed to PCI.
// (R4) Diagnostic bit 4 set disables delayed-transaction handling.
// (R5) Diagnostic bit 3 set lengthens the retry latency limit from 16 to 64.
// (R6) Diagnostic bit 2 picks the card-side discard timer, 2^10 or 2^15.
// (R7) Diagnostic bit 1 picks the host-side discard timer, 2^10 or 2^15.
// (R8) Diagnostic bits and the cold-wake bit reset only on global reset.
// (R9) Host software writes diagnostic bits 7 and 5 to 1 freely and only zero to bit 0.
// (R10) The capability identifier always reads 01h.
// (R11) The next-capability pointer always reads 00h.
// (R12) The capabilities register resets to FE12h.
// (R13) Capabilities bit 15 (cold-state wake) is writable, default 1.
// (R14) Firmware clears bit 15 when no auxiliary supply exists.
// (R15) Capabilities bits 14 to 11 are read-only ones.
// (R16) Capabilities bit 10 is read-only 1 (state two supported).
// (R17) Capabilities bit 9 is read-only 1 (state one supported).
module pm_capability_diag_regs #(
  parameter int DISCARD_LONG_CYC = 1 << pm_diag_pkg::DISCARD_LONG_EXP
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic global_reset_n,
  input wire pm_diag_pkg::cfg_req_t cfg_req,
  input wire logic [15:0] vendor_ident,
  input wire logic [15:0] device_ident,
  input wire pm_diag_pkg::route_in_t route_in,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic identity_mask_select,
  output logic status_change_route_select,
  output logic delayed_txn_disable,
  output logic retry_latency_extend,
  output logic cardside_discard_timer_select,
  output logic hostside_discard_timer_select,
  output logic status_change_to_pci,
  output logic [6:0] retry_limit,
  output logic [15:0] cardside_discard_len,
  output logic [15:0] hostside_discard_len
);
  import pm_diag_pkg::*;

  localparam logic [15:0] DISCARD_LONG = 16'(DISCARD_LONG_CYC);

  // Dword holding a given byte offset
  function automatic logic [7:0] dword_of(input logic [7:0] off);
    return {off[7:2], 2'b00};
  endfunction

  // ******************************************************************
  // Sticky state: only the global reset returns it to defaults
  // ******************************************************************
  logic [7:0] diag_q, diag_d;
  logic pme_cold_q, pme_cold_d;

  // Host write decode; bit 6 is stored as one on every write, so it reads as a constant one
  always_comb begin
    diag_d = diag_q;
    pme_cold_d = pme_cold_q;
    if (cfg_req.wr && cfg_req.be[3]) begin
      if (cfg_req.addr == dword_of(DIAG_OFFSET)) begin
        diag_d = cfg_req.wdata[31:24]; // see (R4)
        diag_d[DIAG_ONE_BIT] = 1'b1; // see (R2)
      end
      if (cfg_req.addr == dword_of(PWR_CAP_OFFSET)) begin
        pme_cold_d = cfg_req.wdata[16 + PWR_CAP_COLD_BIT]; // see (R13)
      end
    end
  end

  // Ordinary rst_n leaves these alone so a bus reset keeps test setup
  always_ff @(posedge clock) begin
    if (!global_reset_n) begin
      diag_q <= DIAG_RESET; // see (R8)
      pme_cold_q <= PWR_CAP_RESET[PWR_CAP_COLD_BIT]; // see (R12)
    end else begin
      diag_q <= diag_d;
      pme_cold_q <= pme_cold_d;
    end
  end

  // ******************************************************************
  // Derived control for retry, discard timers and interrupt routing
  // ******************************************************************
  logic [6:0] retry_limit_d;
  logic [15:0] cb_len_d, host_len_d;
  logic route_d;

  // Lengths are registered so the outputs are glitch-free flops
  always_comb begin
    retry_limit_d = diag_q[DIAG_RETRY_BIT] ? RETRY_LONG_CYC
                                          : RETRY_SHORT_CYC; // see (R5)
    cb_len_d = diag_q[DIAG_CB_TIM_BIT] ? DISCARD_SHORT_CYC
                                      : DISCARD_LONG; // see (R6)
    host_len_d = diag_q[DIAG_HOST_TIM_BIT] ? DISCARD_SHORT_CYC
                                          : DISCARD_LONG; // see (R7)
    if (diag_q[DIAG_ROUTE_BIT]) begin
      route_d = (route_in.compat_805_hi == ROUTE_ALL_ZERO); // see (R3)
    end else begin
      route_d = route_in.compat_803_bit4; // see (R3)
    end
  end

  // Follows the sticky bits, so it too resets only globally
  always_ff @(posedge clock) begin
    if (!global_reset_n) begin
      retry_limit <= RETRY_SHORT_CYC;
      cardside_discard_len <= DISCARD_LONG;
      hostside_discard_len <= DISCARD_LONG;
    end else begin
      retry_limit <= retry_limit_d;
      cardside_discard_len <= cb_len_d;
      hostside_discard_len <= host_len_d;
    end
  end

  // Routing result is not sticky; an ordinary reset parks it low
  always_ff @(posedge clock) begin
    if (!rst_n || !global_reset_n) begin
      status_change_to_pci <= 1'b0;
    end else begin
      status_change_to_pci <= route_d;
    end
  end

  // Select bits leave straight from the sticky flops
  always_comb begin
    identity_mask_select = diag_q[DIAG_MASK_BIT];
    status_change_route_select = diag_q[DIAG_ROUTE_BIT];
    delayed_txn_disable = diag_q[DIAG_DTX_OFF_BIT]; // see (R4)
    retry_latency_extend = diag_q[DIAG_RETRY_BIT];
    cardside_discard_timer_select = diag_q[DIAG_CB_TIM_BIT];
    hostside_discard_timer_select = diag_q[DIAG_HOST_TIM_BIT];
  end

  // ******************************************************************
  // Configuration read path, one cycle latency
  // ******************************************************************
  logic [31:0] rdata_d, cfg_rdata_d;
  logic cfg_rvalid_d;
  logic [7:0] diag_view;
  logic [15:0] pwr_cap_view;

  // Unmapped dwords and bytes of neighbouring registers read as zero
  always_comb begin
    diag_view = diag_q;
    diag_view[DIAG_ONE_BIT] = 1'b1; // see (R2)
    pwr_cap_view = PWR_CAP_RESET; // see (R15) (R16) (R17)
    pwr_cap_view[PWR_CAP_COLD_BIT] = pme_cold_q; // see (R13)
    rdata_d = 32'h00000000;
    if (cfg_req.addr == dword_of(IDENT_OFFSET)) begin
      rdata_d = diag_q[DIAG_MASK_BIT] ? IDENT_MASKED
                : {device_ident, vendor_ident}; // see (R1)
    end else if (cfg_req.addr == dword_of(DIAG_OFFSET)) begin
      rdata_d = {diag_view, 24'h000000};
    end else if (cfg_req.addr == dword_of(CAP_ID_OFFSET)) begin
      rdata_d = {pwr_cap_view, NEXT_PTR_VALUE, // see (R11)
                 CAP_ID_VALUE}; // see (R10)
    end
  end

  // Data holds until the next read, so a slow host still sees its answer
  always_comb begin
    cfg_rvalid_d = cfg_req.rd;
    cfg_rdata_d = cfg_rdata;
    if (cfg_req.rd) begin
      cfg_rdata_d = rdata_d;
    end
  end

  // Valid is a one-cycle pulse; only the bus reset clears the answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= cfg_rdata_d;
      cfg_rvalid <= cfg_rvalid_d;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  id_mask_a: assert property (@(posedge clock) disable iff (!rst_n) // see (R1)
    cfg_req.rd && cfg_req.addr == IDENT_OFFSET && identity_mask_select
    |=> cfg_rvalid && cfg_rdata == IDENT_MASKED)
    else $error("identity not masked");

  id_true_a: assert property (@(posedge clock) disable iff (!rst_n) // see (R1)
    cfg_req.rd && cfg_req.addr == IDENT_OFFSET && !identity_mask_select
    |=> cfg_rdata == {$past(device_ident), $past(vendor_ident)})
    else $error("identity value wrong");

  diag_one_a: assert property (@(posedge clock) // see (R2)
    disable iff (!rst_n)
    cfg_req.rd && cfg_req.addr == dword_of(DIAG_OFFSET)
    |=> cfg_rdata[24 + DIAG_ONE_BIT])
    else $error("diagnostic bit 6 not one");

  csc_route_a: assert property (@(posedge clock) // see (R3)
    disable iff (!rst_n || !global_reset_n)
    $past(rst_n) && $past(global_reset_n) |-> status_change_to_pci ==
    ($past(status_change_route_select)
      ? ($past(route_in.compat_805_hi) == ROUTE_ALL_ZERO)
      : $past(route_in.compat_803_bit4)))
    else $error("status change routing wrong");

  dtx_write_a: assert property (@(posedge clock) // see (R4)
    disable iff (!global_reset_n)
    cfg_req.wr && cfg_req.be[3] && cfg_req.addr == dword_of(DIAG_OFFSET)
    |=> delayed_txn_disable == $past(cfg_req.wdata[24 + DIAG_DTX_OFF_BIT]))
    else $error("delayed transaction disable not written");

  retry_len_a: assert property (@(posedge clock) // see (R5)
    disable iff (!global_reset_n)
    $past(global_reset_n) |-> retry_limit ==
    ($past(retry_latency_extend) ? RETRY_LONG_CYC : RETRY_SHORT_CYC))
    else $error("retry limit wrong");

  cb_discard_a: assert property (@(posedge clock) // see (R6)
    disable iff (!global_reset_n)
    $past(global_reset_n) |-> cardside_discard_len ==
    ($past(cardside_discard_timer_select) ? DISCARD_SHORT_CYC : DISCARD_LONG))
    else $error("card-side discard length wrong");

  host_discard_a: assert property (@(posedge clock) // see (R7)
    disable iff (!global_reset_n)
    $past(global_reset_n) |-> hostside_discard_len ==
    ($past(hostside_discard_timer_select) ? DISCARD_SHORT_CYC : DISCARD_LONG))
    else $error("host-side discard length wrong");

  sticky_hold_a: assert property (@(posedge clock) // see (R8)
    global_reset_n && !rst_n && !cfg_req.wr
    |=> $stable(diag_q) && $stable(pme_cold_q))
    else $error("sticky bits disturbed by ordinary reset");

  global_reset_n_default_a: assert property (@(posedge clock) // see (R12)
    !global_reset_n |=> diag_q == DIAG_RESET && pme_cold_q)
    else $error("global reset defaults wrong");

  cap_head_a: assert property (@(posedge clock) // see (R10)
    disable iff (!rst_n)
    cfg_req.rd && cfg_req.addr == CAP_ID_OFFSET
    |=> cfg_rdata[15:0] == {NEXT_PTR_VALUE, CAP_ID_VALUE}
      && cfg_rdata[30:16] == PWR_CAP_RESET[14:0])
    else $error("capability header wrong");

  cold_wake_a: assert property (@(posedge clock) // see (R13)
    disable iff (!global_reset_n)
    cfg_req.wr && cfg_req.be[3] && cfg_req.addr == CAP_ID_OFFSET
    |=> pme_cold_q == $past(cfg_req.wdata[31]))
    else $error("cold wake bit not written");

  // Writes land in the very next cycle on the select outputs
  mask_write_a: assert property (@(posedge clock) // see (R1)
    disable iff (!global_reset_n)
    cfg_req.wr && cfg_req.be[3] && cfg_req.addr == dword_of(DIAG_OFFSET)
    |=> identity_mask_select == $past(cfg_req.wdata[24 + DIAG_MASK_BIT]))
    else $error("identity mask select not written");

  // Nothing but a diagnostic write or the global reset may move the bits
  diag_hold_a: assert property (@(posedge clock) // see (R8)
    disable iff (!global_reset_n)
    !(cfg_req.wr && cfg_req.be[3]
      && cfg_req.addr == dword_of(DIAG_OFFSET))
    |=> $stable(diag_q))
    else $error("diagnostic bits moved without a write");

  // Readback shows every stored bit, bit 6 aside
  diag_read_a: assert property (@(posedge clock) // see (R8)
    disable iff (!rst_n)
    cfg_req.rd && cfg_req.addr == dword_of(DIAG_OFFSET)
    |=> cfg_rdata[31] == $past(diag_q[DIAG_MASK_BIT])
      && cfg_rdata[29:24] == $past(diag_q[5:0]))
    else $error("diagnostic readback wrong");

  cold_read_a: assert property (@(posedge clock) // see (R13)
    disable iff (!rst_n)
    cfg_req.rd && cfg_req.addr == CAP_ID_OFFSET
    |=> cfg_rdata[16 + PWR_CAP_COLD_BIT] == $past(pme_cold_q))
    else $error("cold wake bit readback wrong");

  // Derived lengths restart at short retry and long discard
  limit_reset_a: assert property (@(posedge clock) // see (R8)
    !global_reset_n |=> retry_limit == RETRY_SHORT_CYC
      && cardside_discard_len == DISCARD_LONG
      && hostside_discard_len == DISCARD_LONG)
    else $error("derived lengths not reset");

  // A bus reset parks the routing result so no stale request escapes
  route_park_a: assert property (@(posedge clock) // see (R3)
    !rst_n |=> !status_change_to_pci)
    else $error("routing result not parked by reset");

  mask_read_c: cover property (@(posedge clock) disable iff (!rst_n)
    identity_mask_select && cfg_req.rd && cfg_req.addr == IDENT_OFFSET);
  cold_clear_c: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(pme_cold_q));
  long_retry_c: cover property (@(posedge clock) disable iff (!rst_n)
    retry_limit == RETRY_LONG_CYC);
  route_low_c: cover property (@(posedge clock) disable iff (!rst_n)
    !status_change_route_select && status_change_to_pci);
  global_reset_n_mid_c: cover property (@(posedge clock)
    rst_n && $fell(global_reset_n));

endmodule
`default_nettype wire

// [testbench/pm_host_model.sv]
// Host model: issues configuration reads and writes to the register block
`timescale 1ns/100ps
`default_nettype none
module pm_host_model (
  input wire logic clock,
  output var pm_diag_pkg::cfg_req_t cfg_req
);
  import pm_diag_pkg::*;

  initial begin
    cfg_req = '0;
  end

  // ************************************************************
  // Bus cycle
  // ************************************************************
  // One request, raised after a falling edge and held over one rising edge
  task automatic access(input logic rd, input logic wr,
                        input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata);
    @(negedge clock);
    cfg_req.rd = rd;
    cfg_req.wr = wr;
    cfg_req.addr = addr;
    cfg_req.be = be;
    cfg_req.wdata = wdata;
    if (wr && addr == {DIAG_OFFSET[7:2], 2'b00}) begin
      cfg_req.wdata[24] = 1'b0; // Reserved bit is always driven as zero
    end
    @(negedge clock);
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
    // Released data flips so a stale value cannot pass for a fresh one
    cfg_req.wdata = ~cfg_req.wdata;
  endtask
endmodule
`default_nettype wire

// [testbench/pm_capability_diag_regs_bench.sv]
// Testbench: self-checking run of the diagnostic and capability registers
`timescale 1ns/100ps
`default_nettype none
module pm_capability_diag_regs_bench;
  import pm_diag_pkg::*;
  localparam int LONG_CYC = 1 << DISCARD_LONG_EXP;
  localparam logic [7:0] DIAG_DW = {DIAG_OFFSET[7:2], 2'b00};
  logic clock, rst_n, global_reset_n, cfg_rvalid, to_pci;
  logic mask_o, route_o, dtx_o, retry_o, cb_o, host_o;
  cfg_req_t cfg_req;
  route_in_t route_in;
  logic [15:0] vendor_ident, device_ident, cb_len, host_len;
  logic [31:0] cfg_rdata;
  logic [6:0] retry_limit;
  logic [31:0] exp_q[$];
  logic [7:0] diag_v;
  int num_errors, compares, i;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  pm_capability_diag_regs #(.DISCARD_LONG_CYC(LONG_CYC)) dut_u (
    .clock(clock), .rst_n(rst_n), .global_reset_n(global_reset_n),
    .cfg_req(cfg_req), .vendor_ident(vendor_ident),
    .device_ident(device_ident), .route_in(route_in),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .identity_mask_select(mask_o), .status_change_route_select(route_o),
    .delayed_txn_disable(dtx_o), .retry_latency_extend(retry_o),
    .cardside_discard_timer_select(cb_o),
    .hostside_discard_timer_select(host_o),
    .status_change_to_pci(to_pci), .retry_limit(retry_limit),
    .cardside_discard_len(cb_len), .hostside_discard_len(host_len)
  );
  pm_host_model host_u (.clock(clock), .cfg_req(cfg_req));

  // ************************************************************
  // Checking tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] got);
    compares++;
    if (got !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, e, got);
    end
  endtask

  // Read results are noted here and matched by the watcher below
  task automatic rd(input logic [7:0] addr, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.access(1'b1, 1'b0, addr, 4'h0, 32'h0);
  endtask

  // Two spare cycles let the derived lengths and routing settle
  task automatic wr(input logic [7:0] addr, input logic [3:0] be,
                    input logic [31:0] d);
    host_u.access(1'b0, 1'b1, addr, be, d);
    repeat (2) @(negedge clock);
  endtask

  task automatic chk_diag(input logic [7:0] v);
    rd(DIAG_DW, {v | 8'h40, 24'h0});
    rd(IDENT_OFFSET,
       v[7] ? 32'hFFFFFFFF : {device_ident, vendor_ident});
    chk("selects", {26'h0, v[7], v[5:1]},
        {26'h0, mask_o, route_o, dtx_o, retry_o, cb_o, host_o});
    chk("retry_limit", v[3] ? 32'h40 : 32'h10,
        {25'h0, retry_limit});
    chk("cardside_len", v[2] ? 32'h400 : 32'(LONG_CYC),
        {16'h0, cb_len});
    chk("hostside_len", v[1] ? 32'h400 : 32'(LONG_CYC),
        {16'h0, host_len});
  endtask

  task automatic finish_test();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watcher: every read answer takes the oldest noted value
  always @(negedge clock) begin
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("unexpected cfg_rdata: expected none seen %h", cfg_rdata);
      end else begin
        chk("cfg_rdata", exp_q.pop_front(), cfg_rdata);
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(98));
    rst_n = 1'b0;
    global_reset_n = 1'b0;
    vendor_ident = 16'($urandom);
    device_ident = 16'($urandom);
    route_in = '0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    global_reset_n = 1'b1;
    chk_diag(8'h60);
    rd(CAP_ID_OFFSET, 32'hFE120001);
    wr(DIAG_DW, 4'h8, 32'hBE000000);
    chk_diag(8'hBE);
    for (i = 0; i < 12; i++) begin
      diag_v = 8'($urandom) & 8'hFE;
      wr(DIAG_DW, 4'h8, {diag_v, 24'h0});
      chk_diag(diag_v);
    end
    // Lane 3 disabled: the diagnostic byte must not move
    wr(DIAG_DW, 4'h7, 32'hFFFFFFFF);
    chk_diag(diag_v);
    wr(CAP_ID_OFFSET, 4'hF, 32'h0);
    rd(CAP_ID_OFFSET, 32'h7E120001);
    // Routing under both selects, register 805 field often zero
    for (i = 0; i < 16; i++) begin
      wr(DIAG_DW, 4'h8, i[0] ? 32'h20000000 : 32'h0);
      route_in = 5'($urandom);
      if (i[1]) begin
        route_in.compat_805_hi = 4'h0;
      end
      repeat (2) @(negedge clock);
      chk("to_pci", {31'h0, i[0] ? route_in.compat_805_hi == 4'h0
                                 : route_in.compat_803_bit4},
          {31'h0, to_pci});
    end
    // Bus reset leaves sticky bits alone; global reset restores them
    wr(DIAG_DW, 4'h8, 32'hBE000000);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk_diag(8'hBE);
    rd(CAP_ID_OFFSET, 32'h7E120001);
    global_reset_n = 1'b0;
    repeat (2) @(negedge clock);
    global_reset_n = 1'b1;
    chk_diag(8'h60);
    rd(CAP_ID_OFFSET, 32'hFE120001);
    for (i = 0; i < 8 && exp_q.size() > 0; i++) begin
      @(negedge clock);
    end
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("unexpected pending_reads: expected 0 seen %0d", exp_q.size());
    end
    finish_test();
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("unexpected run_end: expected finish seen timeout");
    finish_test();
  end
endmodule
`default_nettype wire
